/* File: common/cts_pkg.sv */
// package: offsets, fields, resets and encodings of the cts number select
package cts_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int BYTE_W = 10;
  localparam int SLOT_W = 8;
  localparam int ADDR_W = 28;
  localparam int PADDR_W = 8;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTS_NUM = 8'h00;
  localparam logic [7:0] OFF_IF_CTL = 8'h04;
  localparam logic [7:0] OFF_IF_ESR = 8'h08;
  localparam logic [7:0] OFF_UNIT_ISR = 8'h0C;
  localparam logic [7:0] OFF_UNIT_IMR = 8'h10;
  localparam logic [7:0] OFF_UNIT_EQP = 8'h14;
  localparam logic [7:0] OFF_SLOT_MAP = 8'h18;
  localparam logic [7:0] OFF_ADDR_DEC = 8'h1C;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTS_EVEN_LSB = 0;
  localparam int CTS_ODD_LSB = 16;
  localparam int CTL_OVERRIDE_BIT = 0;
  localparam int ESR_ERR_BIT = 0;
  localparam int ESR_ONES_BIT = 1;
  localparam int ISR_UNEQP_BIT = 0;
  localparam int ISR_ONES_BIT = 1;
  localparam int EQP_PRESENT_BIT = 0;
  localparam int MAP_SLOT_LSB = 16;
  localparam int DEC_INDEX_LSB = 0;
  localparam int DEC_CLASS_LSB = 4;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [BYTE_W-1:0] RST_OVR_BYTE = 10'h3FF;
  localparam logic RST_OVERRIDE = 1'b0;
  localparam logic [1:0] RST_FLAGS = 2'h0;
  localparam logic [1:0] RST_IMR = 2'h0;

  // ------------------------------------------------------------
  // slot to link byte mapping
  // ------------------------------------------------------------
  localparam logic [BYTE_W-1:0] MAP_GROUP_STRIDE = 10'h010;
  localparam logic [BYTE_W-1:0] MAP_SLOT_STRIDE = 10'h002;
  localparam logic [BYTE_W-1:0] MAP_OFFSET = 10'h002;

  // ------------------------------------------------------------
  // unit address decode (longword addresses)
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SLICE_BASE = 28'hC080000;
  localparam int SLICE_SHIFT = 15;
  localparam logic [3:0] SLICE_COUNT = 4'hA;
  localparam logic [ADDR_W-1:0] PORT_BASE = 28'hC0D8000;
  localparam int PORT_SHIFT = 14;
  localparam logic [3:0] PORT_COUNT = 4'h6;
  localparam logic [ADDR_W-1:0] COMMON_BASE = 28'hC0F0000;
  localparam logic [ADDR_W-1:0] COMMON_WORDS = 28'h0000800;

  typedef enum logic [1:0] {
    CLASS_NONE = 2'b00,
    CLASS_SLICE = 2'b01,
    CLASS_PORT = 2'b10,
    CLASS_COMMON = 2'b11
  } unit_class_t;

  // message link block number carries this cts source
  typedef enum logic [1:0] {
    SRC_SIDE0_EVEN = 2'b00,
    SRC_SIDE0_ODD = 2'b01,
    SRC_SIDE1_EVEN = 2'b10,
    SRC_SIDE1_ODD = 2'b11
  } cts_source_t;

endpackage : cts_pkg

/* File: verilog/cts_map.sv */
// slot to link byte mapping and unit address decode
`timescale 1ns/100ps
`default_nettype none

module cts_map (
  input wire logic [cts_pkg::SLOT_W-1:0] slot, // network time slot
  input wire logic [cts_pkg::ADDR_W-1:0] addr, // longword address
  output logic [cts_pkg::BYTE_W-1:0] link_byte, // mapped link byte
  output cts_pkg::unit_class_t unit_class, // board class hit
  output logic [3:0] unit_index // board number in class
);

  // ------------------------------------------------------------
  // slot mapping: groups of four slots, 16 bytes apart
  // ------------------------------------------------------------
  wire logic [cts_pkg::BYTE_W-1:0] grp;
  wire logic [cts_pkg::BYTE_W-1:0] sub;
  assign grp = cts_pkg::BYTE_W'(slot[7:2]);
  assign sub = cts_pkg::BYTE_W'(slot[1:0]);
  assign link_byte = cts_pkg::BYTE_W'(grp * cts_pkg::MAP_GROUP_STRIDE
    + sub * cts_pkg::MAP_SLOT_STRIDE + cts_pkg::MAP_OFFSET);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire logic [cts_pkg::ADDR_W-1:0] slice_off;
  wire logic [cts_pkg::ADDR_W-1:0] port_off;
  wire logic [cts_pkg::ADDR_W-1:0] com_off;
  wire logic [cts_pkg::ADDR_W-1:0] slice_num;
  wire logic [cts_pkg::ADDR_W-1:0] port_num;
  wire logic slice_hit;
  wire logic port_hit;
  wire logic com_hit;
  assign slice_off = addr - cts_pkg::SLICE_BASE;
  assign port_off = addr - cts_pkg::PORT_BASE;
  assign com_off = addr - cts_pkg::COMMON_BASE;
  assign slice_num = slice_off >> cts_pkg::SLICE_SHIFT;
  assign port_num = port_off >> cts_pkg::PORT_SHIFT;
  assign slice_hit = (addr >= cts_pkg::SLICE_BASE)
    && (slice_num < cts_pkg::ADDR_W'(cts_pkg::SLICE_COUNT));
  assign port_hit = (addr >= cts_pkg::PORT_BASE)
    && (port_num < cts_pkg::ADDR_W'(cts_pkg::PORT_COUNT));
  assign com_hit = (addr >= cts_pkg::COMMON_BASE)
    && (com_off < cts_pkg::COMMON_WORDS);
  assign unit_class = slice_hit ? cts_pkg::CLASS_SLICE :
    port_hit ? cts_pkg::CLASS_PORT :
    com_hit ? cts_pkg::CLASS_COMMON : cts_pkg::CLASS_NONE;
  assign unit_index = slice_hit ? slice_num[3:0] :
    port_hit ? port_num[3:0] : 4'h0;

endmodule : cts_map

`default_nettype wire

/* File: verilog/cts_number_select.sv */
// cts byte number select: switch banks, override, flags, apb registers
//
// Contract
// - separate even and odd byte numbers, both sides
// - configured byte number readable in register
// - absent board sets unequipped error flag
// - absent board clears board present bit
// - absent board sets error and all-ones flags (the ISR all-ones bit is not forced, it follows the switch pins)
// - all-ones flag when switch value all ones
// - four ctss placed in message link blocks
// - slot n maps to 16(n/4)+2(n%4)+2
// - decode slice, port and common board ranges
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module cts_number_select #(
  parameter int BYTE_W = cts_pkg::BYTE_W // cts byte number width
) (
  input wire logic pclk, // apb clock, 40 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [cts_pkg::PADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [BYTE_W-1:0] sw_even_bank, // even-link switch pins
  input wire logic [BYTE_W-1:0] sw_odd_bank, // odd-link switch pins
  input wire logic board_present_n, // switch board present, low
  input wire logic mcp_slot_p0, // message link at slot p0
  input wire logic [1:0] mcp_block, // message link block number
  output logic [BYTE_W-1:0] cts_even_byte_q, // byte in use, even links
  output logic [BYTE_W-1:0] cts_odd_byte_q, // byte in use, odd links
  output logic mcp_cts_valid_q, // cts goes into message link
  output cts_pkg::cts_source_t mcp_cts_source_q, // which cts
  output logic [BYTE_W-1:0] mcp_cts_byte_q, // link byte of that cts
  output logic irq_q // unit interrupt, level
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [BYTE_W-1:0] even_s1_q;
  logic [BYTE_W-1:0] even_s2_q;
  logic [BYTE_W-1:0] odd_s1_q;
  logic [BYTE_W-1:0] odd_s2_q;
  logic absent_s1_q;
  logic absent_s2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      even_s1_q <= '0;
      even_s2_q <= '0;
      odd_s1_q <= '0;
      odd_s2_q <= '0;
      absent_s1_q <= 1'b0;
      absent_s2_q <= 1'b0;
    end else begin
      even_s1_q <= sw_even_bank;
      even_s2_q <= even_s1_q;
      odd_s1_q <= sw_odd_bank;
      odd_s2_q <= odd_s1_q;
      absent_s1_q <= board_present_n;
      absent_s2_q <= absent_s1_q;
    end
  end

  // ------------------------------------------------------------
  // registers and bus decode
  // ------------------------------------------------------------
  logic override_q;
  logic [BYTE_W-1:0] ovr_even_q;
  logic [BYTE_W-1:0] ovr_odd_q;
  logic [1:0] esr_q;
  logic [1:0] isr_q;
  logic [1:0] imr_q;
  logic [cts_pkg::SLOT_W-1:0] slot_q;
  logic [cts_pkg::ADDR_W-1:0] dec_addr_q;

  wire logic acc_first;
  wire logic acc_done;
  wire logic wr_en;
  wire logic sel_cts;
  wire logic sel_ctl;
  wire logic sel_esr;
  wire logic sel_isr;
  wire logic sel_imr;
  wire logic sel_eqp;
  wire logic sel_map;
  wire logic sel_dec;
  wire logic mapped;
  // one wait state: ready rises on the first access edge, data with it
  assign acc_first = psel & penable & ~pready;
  assign acc_done = psel & penable & pready;
  assign wr_en = acc_done & pwrite & mapped;
  assign sel_cts = paddr == cts_pkg::OFF_CTS_NUM;
  assign sel_ctl = paddr == cts_pkg::OFF_IF_CTL;
  assign sel_esr = paddr == cts_pkg::OFF_IF_ESR;
  assign sel_isr = paddr == cts_pkg::OFF_UNIT_ISR;
  assign sel_imr = paddr == cts_pkg::OFF_UNIT_IMR;
  assign sel_eqp = paddr == cts_pkg::OFF_UNIT_EQP;
  assign sel_map = paddr == cts_pkg::OFF_SLOT_MAP;
  assign sel_dec = paddr == cts_pkg::OFF_ADDR_DEC;
  assign mapped = sel_cts | sel_ctl | sel_esr | sel_isr | sel_imr
    | sel_eqp | sel_map | sel_dec;

  // ------------------------------------------------------------
  // byte number selection and flag sources
  // ------------------------------------------------------------
  wire logic [BYTE_W-1:0] eff_even;
  wire logic [BYTE_W-1:0] eff_odd;
  wire logic all_ones;
  wire logic [1:0] esr_set;
  wire logic [1:0] isr_set;
  wire logic [1:0] esr_d;
  wire logic [1:0] isr_d;
  assign eff_even = override_q ? ovr_even_q : even_s2_q;
  assign eff_odd = override_q ? ovr_odd_q : odd_s2_q;
  assign all_ones = (&even_s2_q) | (&odd_s2_q);
  // an absent board reads all ones anyway; both esr flags are forced, the isr ones bit is not
  assign esr_set = {all_ones | absent_s2_q, absent_s2_q};
  assign isr_set = {all_ones, absent_s2_q};
  // set wins over a write-one clear in the same cycle
  assign esr_d = (esr_q & ~((wr_en & sel_esr) ? pwdata[1:0] : 2'h0))
    | esr_set;
  assign isr_d = (isr_q & ~((wr_en & sel_isr) ? pwdata[1:0] : 2'h0))
    | isr_set;

  // ------------------------------------------------------------
  // mapping and decode helpers
  // ------------------------------------------------------------
  wire logic [BYTE_W-1:0] map_byte;
  cts_pkg::unit_class_t dec_class;
  wire logic [3:0] dec_index;

  cts_map u_map (
    .slot(slot_q),
    .addr(dec_addr_q),
    .link_byte(map_byte),
    .unit_class(dec_class),
    .unit_index(dec_index)
  );

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0;
    if (sel_cts) begin
      rd_data[cts_pkg::CTS_EVEN_LSB +: BYTE_W] = eff_even;
      rd_data[cts_pkg::CTS_ODD_LSB +: BYTE_W] = eff_odd;
    end
    if (sel_ctl) rd_data[cts_pkg::CTL_OVERRIDE_BIT] = override_q;
    if (sel_esr) rd_data[1:0] = esr_q;
    if (sel_isr) rd_data[1:0] = isr_q;
    if (sel_imr) rd_data[1:0] = imr_q;
    if (sel_eqp) rd_data[cts_pkg::EQP_PRESENT_BIT] = ~absent_s2_q;
    if (sel_map) begin
      rd_data[BYTE_W-1:0] = map_byte;
      rd_data[cts_pkg::MAP_SLOT_LSB +: cts_pkg::SLOT_W] = slot_q;
    end
    if (sel_dec) begin
      rd_data[cts_pkg::DEC_INDEX_LSB +: 4] = dec_index;
      rd_data[cts_pkg::DEC_CLASS_LSB +: 2] = dec_class;
    end
  end

  // ------------------------------------------------------------
  // apb answer
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc_first;
      pslverr <= acc_first & ~mapped;
      if (acc_first) prdata <= rd_data;
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      override_q <= cts_pkg::RST_OVERRIDE;
      ovr_even_q <= cts_pkg::RST_OVR_BYTE;
      ovr_odd_q <= cts_pkg::RST_OVR_BYTE;
      imr_q <= cts_pkg::RST_IMR;
      slot_q <= '0;
      dec_addr_q <= '0;
    end else if (wr_en) begin
      if (sel_ctl) override_q <= pwdata[cts_pkg::CTL_OVERRIDE_BIT];
      // writes land even without override, so the number is ready first
      if (sel_cts) begin
        ovr_even_q <= pwdata[cts_pkg::CTS_EVEN_LSB +: BYTE_W];
        ovr_odd_q <= pwdata[cts_pkg::CTS_ODD_LSB +: BYTE_W];
      end
      if (sel_imr) imr_q <= pwdata[1:0];
      if (sel_map) slot_q <= pwdata[cts_pkg::SLOT_W-1:0];
      if (sel_dec) dec_addr_q <= pwdata[cts_pkg::ADDR_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // flags, interrupt, outputs
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      esr_q <= cts_pkg::RST_FLAGS;
      isr_q <= cts_pkg::RST_FLAGS;
      irq_q <= 1'b0;
      cts_even_byte_q <= '0;
      cts_odd_byte_q <= '0;
    end else begin
      esr_q <= esr_d;
      isr_q <= isr_d;
      irq_q <= |(isr_d & imr_q);
      cts_even_byte_q <= eff_even;
      cts_odd_byte_q <= eff_odd;
    end
  end

  // message link placement: block number picks side and parity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcp_cts_valid_q <= 1'b0;
      mcp_cts_source_q <= cts_pkg::SRC_SIDE0_EVEN;
      mcp_cts_byte_q <= '0;
    end else begin
      mcp_cts_valid_q <= mcp_slot_p0;
      if (mcp_slot_p0) begin
        mcp_cts_source_q <= cts_pkg::cts_source_t'(mcp_block);
        mcp_cts_byte_q <= mcp_block[0] ? eff_odd : eff_even;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_read(logic sel);
    psel && !penable && !pwrite && sel ##1 psel && penable;
  endsequence

  AST_SWITCH_SELECT: assert property (
    !override_q |=> cts_even_byte_q == $past(even_s2_q)
      && cts_odd_byte_q == $past(odd_s2_q))
    else $error("switch value not used without override");

  AST_CTS_READ: assert property (
    s_read(sel_cts) |=> pready
      && prdata[BYTE_W-1:0] == $past(eff_even, 1))
    else $error("cts number read does not show byte in use");

  AST_ABSENT_ISR: assert property (
    absent_s2_q |=> isr_q[cts_pkg::ISR_UNEQP_BIT] ##1
      isr_q[cts_pkg::ISR_UNEQP_BIT] || !$past(absent_s2_q))
    else $error("unequipped error not set with board absent");

  AST_ABSENT_EQP: assert property (
    s_read(sel_eqp) ##0 (absent_s2_q && $past(absent_s2_q))
      |=> !prdata[0])
    else $error("present bit reads one with board absent");

  AST_ABSENT_ESR: assert property (
    absent_s2_q |=> esr_q == 2'h3)
    else $error("error flags not both set with board absent");

  AST_ALL_ONES: assert property (
    &even_s2_q |=> esr_q[cts_pkg::ESR_ONES_BIT]
      && isr_q[cts_pkg::ISR_ONES_BIT])
    else $error("all-ones flag not set");

  AST_OVERRIDE: assert property (
    override_q |=> cts_odd_byte_q == $past(ovr_odd_q)
      && cts_even_byte_q == $past(ovr_even_q))
    else $error("override number not used");

  AST_MCP_PLACE: assert property (
    mcp_slot_p0 && mcp_block == 2'h3 |=> mcp_cts_valid_q
      && mcp_cts_source_q == cts_pkg::SRC_SIDE1_ODD
      && mcp_cts_byte_q == $past(eff_odd))
    else $error("cts not placed in its message link block");

  AST_SLOT_MAP: assert property (
    slot_q == 8'hFF |-> map_byte == 10'h3F8)
    else $error("last slot does not map to final link byte");

  AST_DECODE: assert property (
    dec_addr_q == 28'hC0D0000 |-> dec_class == cts_pkg::CLASS_NONE)
    else $error("unused gap decoded as a board");

endmodule : cts_number_select

`default_nettype wire

/* File: sim/cts_far_side.sv */
// far-side model: cts number switch board and message link source
`timescale 1ns/100ps
`default_nettype none

module cts_far_side (
  input wire logic pclk, // bench clock
  input wire logic fitted, // board plugged in
  input wire logic [cts_pkg::BYTE_W-1:0] even_set, // even switch value
  input wire logic [cts_pkg::BYTE_W-1:0] odd_set, // odd switch value
  input wire logic p0_req, // send slot p0 now
  input wire logic [1:0] p0_blk, // block of that slot
  output logic [cts_pkg::BYTE_W-1:0] sw_even_bank, // even pins
  output logic [cts_pkg::BYTE_W-1:0] sw_odd_bank, // odd pins
  output logic board_present_n, // low while fitted
  output logic mcp_slot_p0, // slot p0 strobe
  output logic [1:0] mcp_block // block number
);
  initial begin
    sw_even_bank = '1;
    sw_odd_bank = '1;
    board_present_n = 1'b1;
    mcp_slot_p0 = 1'b0;
    mcp_block = 2'h0;
  end

  // one setting stands for the boards of both service groups
  // unfitted pins float to their pull-ups, so they read all ones
  always @(posedge pclk) begin
    sw_even_bank <= fitted ? even_set : '1;
    sw_odd_bank <= fitted ? odd_set : '1;
    board_present_n <= ~fitted;
    mcp_slot_p0 <= p0_req;
    // block lines only mean something at p0; keep them moving elsewhere
    mcp_block <= p0_req ? p0_blk : mcp_block + 2'h1;
  end
endmodule : cts_far_side
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the cts byte number select block
`timescale 1ns/100ps
`default_nettype none

module tb;
  localparam int BW = cts_pkg::BYTE_W;
  localparam logic [31:0] PM = 32'h03FF03FF;
  typedef struct {
    string name;
    logic [31:0] exp;
    logic [31:0] mask;
    logic err;
  } note_t;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_q;
  logic fitted, p0_req, board_present_n, mcp_slot_p0, mcp_cts_valid_q;
  logic p0_seen;
  logic [1:0] p0_blk, mcp_block;
  logic [7:0] paddr, slot;
  logic [31:0] pwdata, prdata, exp_w, msk;
  logic [27:0] addr;
  logic [11:0] exp_l;
  logic [BW-1:0] even_set, odd_set, ov_even, ov_odd, keep, sw_even_bank;
  logic [BW-1:0] sw_odd_bank, cts_even_byte_q, cts_odd_byte_q;
  logic [BW-1:0] mcp_cts_byte_q;
  cts_pkg::cts_source_t mcp_cts_source_q;
  wire logic [11:0] link_seen = {mcp_cts_source_q, mcp_cts_byte_q};
  int err_count, checks, seed;
  note_t apb_q[$];
  note_t nt;
  logic [11:0] link_q[$];
  logic [7:0] stab [4] = '{8'h00, 8'h03, 8'h04, 8'hFF};
  logic [27:0] atab [10] = '{28'hC07FFFF, 28'hC080000, 28'hC0F0000,
    28'hC088000, 28'hC0CFFFF, 28'hC0D0000, 28'hC0D8000, 28'hC0EFFFF,
    28'hC0F07FF, 28'hC0F0800};

  cts_number_select dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sw_even_bank(sw_even_bank),
    .sw_odd_bank(sw_odd_bank), .board_present_n(board_present_n),
    .mcp_slot_p0(mcp_slot_p0), .mcp_block(mcp_block),
    .cts_even_byte_q(cts_even_byte_q), .cts_odd_byte_q(cts_odd_byte_q),
    .mcp_cts_valid_q(mcp_cts_valid_q), .mcp_cts_source_q(mcp_cts_source_q),
    .mcp_cts_byte_q(mcp_cts_byte_q), .irq_q(irq_q)
  );

  cts_far_side far_u (
    .pclk(pclk), .fitted(fitted), .even_set(even_set), .odd_set(odd_set),
    .p0_req(p0_req), .p0_blk(p0_blk), .sw_even_bank(sw_even_bank),
    .sw_odd_bank(sw_odd_bank), .board_present_n(board_present_n),
    .mcp_slot_p0(mcp_slot_p0), .mcp_block(mcp_block)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // --------------------
  // tasks
  // --------------------
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // the note is queued first; the watcher compares at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input string what, input logic [31:0] exp,
      input logic [31:0] mask);
    apb_q.push_back('{what, exp, mask, a > 8'h1C});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, $sformatf("write %h", a), 32'h0, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
      input logic [31:0] mask);
    apb(1'b0, a, 32'h0, $sformatf("read %h", a), exp, mask);
  endtask : rd

  // four p0 slots back to back, blocks 0 to 3
  task automatic link_burst(input logic [BW-1:0] ev, input logic [BW-1:0] od);
    for (int b = 0; b < 4; b++) begin
      p0_req <= 1'b1;
      p0_blk <= 2'(b);
      link_q.push_back({2'(b), b[0] ? od : ev});
      @(posedge pclk);
    end
    p0_req <= 1'b0;
    tick(4);
  endtask : link_burst

  function automatic logic [31:0] pair(input logic [BW-1:0] ev,
      input logic [BW-1:0] od);
    return {6'h0, od, 6'h0, ev};
  endfunction : pair

  function automatic logic [BW-1:0] map_byte(input int n);
    return BW'(16 * (n / 4) + 2 * (n % 4) + 2);
  endfunction : map_byte

  function automatic logic [5:0] dec(input logic [27:0] a);
    if (a >= 28'hC080000 && a < 28'hC0D0000)
      return {2'h1, 4'((a - 28'hC080000) >> 15)};
    if (a >= 28'hC0D8000 && a < 28'hC0F0000)
      return {2'h2, 4'((a - 28'hC0D8000) >> 14)};
    if (a >= 28'hC0F0000 && a < 28'hC0F0800)
      return 6'h30;
    return 6'h00;
  endfunction : dec

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      nt = apb_q.pop_front();
      check(nt.name, prdata & nt.mask, nt.exp);
      check({nt.name, " err"}, 32'(pslverr), 32'(nt.err));
    end
    if (mcp_cts_valid_q === 1'b1) begin
      exp_l = link_q.pop_front();
      check("link p0", 32'(p0_seen), 32'h1);
      check("link cts", 32'(link_seen), 32'(exp_l));
    end
    p0_seen <= mcp_slot_p0;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    tally_and_finish();
  end

  // --------------------
  // sequence
  // --------------------
  initial begin
    seed = 32'h26B5;
    err_count = 0;
    checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fitted = 1'b1;
    p0_req = 1'b0;
    p0_blk = 2'h0;
    even_set = BW'($random(seed)) >> 1;
    odd_set = BW'($random(seed)) >> 1;
    ov_even = BW'($random(seed));
    ov_odd = BW'($random(seed));
    keep = odd_set;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    tick(6);
    rd(cts_pkg::OFF_CTS_NUM, pair(even_set, odd_set), PM);
    rd(cts_pkg::OFF_IF_CTL, 32'h0, 32'h1);
    rd(cts_pkg::OFF_IF_ESR, 32'h0, 32'h3);
    rd(cts_pkg::OFF_UNIT_ISR, 32'h0, 32'h3);
    rd(cts_pkg::OFF_UNIT_IMR, 32'h0, 32'h3);
    rd(cts_pkg::OFF_UNIT_EQP, 32'h1, 32'h1);
    apb(1'b1, 8'h20, 32'hFFFFFFFF, "write 20", 32'h0, 32'h0);
    apb(1'b0, 8'h20, 32'h0, "read 20", 32'h0, 32'hFFFFFFFF);
    check("even byte", 32'(cts_even_byte_q), 32'(even_set));
    check("odd byte", 32'(cts_odd_byte_q), 32'(odd_set));
    $display("test reset done");
    odd_set <= '1;
    tick(8);
    rd(cts_pkg::OFF_IF_ESR, 32'h2, 32'h3);
    rd(cts_pkg::OFF_UNIT_ISR, 32'h2, 32'h3);
    check("irq masked", 32'(irq_q), 32'h0);
    wr(cts_pkg::OFF_UNIT_IMR, 32'h2);
    tick(2);
    check("irq", 32'(irq_q), 32'h1);
    odd_set <= keep;
    tick(8);
    wr(cts_pkg::OFF_IF_ESR, 32'h3);
    wr(cts_pkg::OFF_UNIT_ISR, 32'h3);
    tick(2);
    rd(cts_pkg::OFF_IF_ESR, 32'h0, 32'h3);
    rd(cts_pkg::OFF_UNIT_ISR, 32'h0, 32'h3);
    check("irq cleared", 32'(irq_q), 32'h0);
    $display("test all ones done");
    wr(cts_pkg::OFF_UNIT_IMR, 32'h1);
    fitted <= 1'b0;
    tick(8);
    rd(cts_pkg::OFF_IF_ESR, 32'h3, 32'h3);
    rd(cts_pkg::OFF_UNIT_ISR, 32'h3, 32'h3);
    rd(cts_pkg::OFF_UNIT_EQP, 32'h0, 32'h1);
    check("irq absent", 32'(irq_q), 32'h1);
    // clearing while the board is still absent must not stick
    wr(cts_pkg::OFF_IF_ESR, 32'h3);
    rd(cts_pkg::OFF_IF_ESR, 32'h3, 32'h3);
    wr(cts_pkg::OFF_IF_CTL, 32'h1);
    rd(cts_pkg::OFF_CTS_NUM, pair(10'h3FF, 10'h3FF), PM);
    wr(cts_pkg::OFF_CTS_NUM, pair(ov_even, ov_odd));
    rd(cts_pkg::OFF_CTS_NUM, pair(ov_even, ov_odd), PM);
    link_burst(ov_even, ov_odd);
    fitted <= 1'b1;
    tick(8);
    wr(cts_pkg::OFF_IF_ESR, 32'h3);
    wr(cts_pkg::OFF_UNIT_ISR, 32'h3);
    wr(cts_pkg::OFF_UNIT_IMR, 32'h0);
    rd(cts_pkg::OFF_UNIT_EQP, 32'h1, 32'h1);
    wr(cts_pkg::OFF_IF_CTL, 32'h0);
    tick(2);
    rd(cts_pkg::OFF_CTS_NUM, pair(even_set, odd_set), PM);
    check("irq idle", 32'(irq_q), 32'h0);
    link_burst(even_set, odd_set);
    $display("test absent and override done");
    for (int i = 0; i < 8; i++) begin
      slot = (i < 4) ? stab[i] : 8'($random(seed));
      exp_w = {8'h0, slot, 6'h0, map_byte(slot)};
      wr(cts_pkg::OFF_SLOT_MAP, 32'(slot));
      rd(cts_pkg::OFF_SLOT_MAP, exp_w, 32'h00FF03FF);
    end
    $display("test slot map done");
    for (int i = 0; i < 16; i++) begin
      addr = (i < 10) ? atab[i] : 28'hC080000 + 28'($random(seed) & 32'h7FFFF);
      exp_w = 32'(dec(addr));
      msk = (exp_w[5] ^ exp_w[4]) ? 32'h3F : 32'h30;
      wr(cts_pkg::OFF_ADDR_DEC, 32'(addr));
      rd(cts_pkg::OFF_ADDR_DEC, exp_w, msk);
    end
    $display("test decode done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
